// >>> smvo_map.vh
// Register map, field positions and reset values of the static memory
// controller register block. Definitions only; included by the top module.
`ifndef SMVO_MAP_VH
`define SMVO_MAP_VH

// ----------------------------------------------------------------
// Register byte addresses.
// ----------------------------------------------------------------
`define SMVO_A_STATUS 12'h000
`define SMVO_A_DCMD 12'h010
`define SMVO_A_SETOP 12'h014
`define SMVO_A_OPSTAT 12'h018
`define SMVO_A_CYC 12'h01c
`define SMVO_A_ACC 12'h020
`define SMVO_A_RDATA 12'h024
`define SMVO_A_ECFG 12'h030
`define SMVO_A_ESTAT 12'h034
`define SMVO_A_ECMD 12'h038
`define SMVO_A_EVAL 12'h03c
`define SMVO_A_ICFG 12'he00
`define SMVO_A_IIN 12'he04
`define SMVO_A_IOUT 12'he08

// ----------------------------------------------------------------
// Field positions and encodings.
// ----------------------------------------------------------------
`define SMVO_DCMD_HI 22
`define SMVO_DCMD_LO 21
`define SMVO_DCMD_UPD 2'b10
`define SMVO_ACC_KIND_HI 17
`define SMVO_ACC_KIND_LO 16
`define SMVO_ACC_CS_HI 21
`define SMVO_ACC_CS_LO 20
`define SMVO_K_CMD 2'b00
`define SMVO_K_ADDR 2'b01
`define SMVO_K_WR 2'b10
`define SMVO_K_RD 2'b11
`define SMVO_W16 2'b01
`define SMVO_ECC_NOMEM 2'b01
`define SMVO_ECC_RSVD 2'b00
`define SMVO_IIN_W 6
`define SMVO_IOUT_MASK 32'h00000027

// ----------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------
`define SMVO_TR_RST 4'h1
`define SMVO_ECFG_RST 12'h001
`define SMVO_IOUT_RST 32'h00000002
`define SMVO_BA_RST 3'b000

`endif

// >>> smvo_chk_ram.v
// Small store for the check values of closed data blocks.
// Assumes one clock; read data come from a register one edge after the address.
`timescale 1ns/10ps

module smvo_chk_ram #(
  parameter DW = 8,
  parameter AW = 4
) (
  input wire clock_i,
  input wire wr_en_i,
  input wire [AW-1:0] wr_addr_i,
  input wire [DW-1:0] wr_data_i,
  input wire [AW-1:0] rd_addr_i,
  output reg [DW-1:0] rd_data_o
);

  reg [DW-1:0] mem_r [0:(1<<AW)-1];

  // Plain synchronous array; no reset so that it maps onto RAM cells.
  always @(posedge clock_i) begin
    if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_r[rd_addr_i];
  end

endmodule

// >>> smvo_ctrl.v
// Register block and memory port 0 sequencer of a NAND static memory
// controller, single interface. Assumes an AXI4-Lite master on clock_i and
// a free running memory clock with its inverted copy from the clock source.
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "smvo_map.vh"

module smvo_ctrl #(
  parameter AXI_DW = 32,
  parameter MEM_DW = 16,
  parameter NUM_CS = 1,
  parameter EXTRA_CFG = 1,
  parameter CHK_AW = 4
) (
  input wire clock_i,
  input wire rst_n_i,
  input wire [11:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [AXI_DW-1:0] s_axi_wdata_i,
  input wire [AXI_DW/8-1:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [11:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  output reg [AXI_DW-1:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire memory_port0_clock_i,
  input wire memory_port0_clock_n_i,
  input wire mem_rst0_n_i,
  input wire mux_mode0_i,
  input wire [15:0] opstat_hi_tie_i,
  input wire [1:0] opstat_lo_tie_i,
  input wire low_power_req_i,
  input wire ext_bus_sel_i,
  input wire ext_bus_grant0_i,
  input wire ext_bus_backoff0_i,
  input wire clk_async0_i,
  input wire clk_msync0_i,
  output reg low_power_active_o,
  output reg low_power_ack_o,
  output reg ext_bus_req0_o,
  output reg mem_int0_o,
  output reg [NUM_CS-1:0] mem_cs0_n_o,
  output reg mem_cle0_o,
  output reg mem_adv0_n_o,
  output reg mem_we0_n_o,
  output reg mem_re0_n_o,
  output reg [MEM_DW-1:0] mem_dq0_o,
  output reg mem_dq0_oe_o,
  input wire [MEM_DW-1:0] mem_dq0_i
);

  localparam ST_IDLE = 2'd0;
  localparam ST_STROBE = 2'd1;
  localparam ST_HOLD = 2'd2;
  localparam ST_GAP = 2'd3;

  // ----------------------------------------------------------------
  // Helper functions.
  // ----------------------------------------------------------------
  // lane pick
  // Picks the 32-bit lane of a wide bus addressed by bit 2.
  function [31:0] lane_w;
    input [AXI_DW-1:0] d;
    input a2;
    begin
      lane_w = (AXI_DW > 32 && a2) ? d[AXI_DW-1 -: 32] : d[31:0];
    end
  endfunction

  // width masking
  // Keeps the low byte only while the bus-width field does not select 16 bits.
  function [15:0] wmask;
    input [15:0] v;
    input w16;
    begin
      wmask = w16 ? v : {8'h00, v[7:0]};
    end
  endfunction

  // Folds one memory word into an 8-bit check contribution.
  function [7:0] fold;
    input [15:0] v;
    input w16;
    begin
      fold = w16 ? (v[7:0] ^ v[15:8]) : v[7:0];
    end
  endfunction

  function [3:0] cs_dec;
    input [1:0] i;
    begin
      cs_dec = 4'h1 << i;
    end
  endfunction

  // ----------------------------------------------------------------
  // Bus clock domain state.
  // ----------------------------------------------------------------
  reg aw_got_r, w_got_r, ar_got_r, pri_rd_r;
  reg [11:0] awaddr_r, araddr_r;
  reg [AXI_DW-1:0] wdata_r;
  reg [AXI_DW/8-1:0] wstrb_r;
  reg [1:0] setop_r, opstat_w_r;
  reg [15:0] opstat_hi_r;
  reg [3:0] cyc_r;
  reg [11:0] ecfg_r;
  reg icfg_r;
  reg [31:0] iout_r;
  reg fail_r;
  reg [CHK_AW-1:0] blk_r;
  reg [7:0] acc_r, exp_r;
  reg [15:0] rdata_r;
  reg req_tgl_r, busy_r, int_req_r, wid_r;
  reg [1:0] kind_r, cs_r;
  reg [15:0] val_r;
  reg [3:0] tr_r;
  reg [`SMVO_IIN_W-1:0] in_s1_r, in_s2_r;
  reg ack_s1_r, ack_s2_r, ack_s3_r;
  reg [31:0] rd_word;
  // Memory clock domain state.
  reg req_m1_r, req_m2_r, seen_r, ack_m_r, mux_m1_r, mux_m2_r;
  reg [1:0] st_r;
  reg [3:0] gap_r;
  reg [MEM_DW-1:0] dq_m1_r, dq_m2_r;
  reg [15:0] mem_rd_r;
  reg [1:0] rd_cnt_r;
  reg [15:0] dq_wide;

  wire [7:0] chk_val;
  wire [31:0] wsel = lane_w(wdata_r, awaddr_r[2]);
  wire [3:0] wstb = wstrb_r[AXI_DW/8-1 -: 4] & {4{AXI_DW > 32 && awaddr_r[2]}}
                  | wstrb_r[3:0] & {4{!(AXI_DW > 32 && awaddr_r[2])}};
  wire wr_rdy = aw_got_r & w_got_r & ~s_axi_bvalid_o;
  wire rd_rdy = ar_got_r & ~s_axi_rvalid_o;
  wire do_wr = wr_rdy & (~rd_rdy | ~pri_rd_r);
  wire do_rd = rd_rdy & (~wr_rdy | pri_rd_r);
  wire w16 = (opstat_w_r == `SMVO_W16);
  wire ack_ev = ack_s2_r ^ ack_s3_r;
  wire ecc_rsvd = (ecfg_r[1:0] == `SMVO_ECC_RSVD) && !(EXTRA_CFG != 0 && ecfg_r[4]);
  wire ecc_mem = (ecfg_r[3:2] != `SMVO_ECC_NOMEM);
  wire ecmd_wr = do_wr && awaddr_r == `SMVO_A_ECMD && wstb[0] && !busy_r && !ecc_rsvd;
  wire close_wr = ecmd_wr && wsel[0];
  wire close_rd = ecmd_wr && !wsel[0] && wsel[1];

  // ----------------------------------------------------------------
  // AXI4-Lite handshakes.
  // ----------------------------------------------------------------
  // One write and one read are held at a time, so completion order is
  // acceptance order; the ready pulses come one cycle after valid.
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_arready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= 2'b00;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o <= 2'b00;
      s_axi_rdata_o <= {AXI_DW{1'b0}};
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      ar_got_r <= 1'b0;
      pri_rd_r <= 1'b0;
      awaddr_r <= 12'h000;
      araddr_r <= 12'h000;
      wdata_r <= {AXI_DW{1'b0}};
      wstrb_r <= {AXI_DW/8{1'b0}};
    end else begin
      s_axi_awready_o <= s_axi_awvalid_i && !aw_got_r && !s_axi_awready_o && !s_axi_bvalid_o;
      s_axi_wready_o <= s_axi_wvalid_i && !w_got_r && !s_axi_wready_o && !s_axi_bvalid_o;
      s_axi_arready_o <= s_axi_arvalid_i && !ar_got_r && !s_axi_arready_o && !s_axi_rvalid_o;
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_got_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr_i[11:2], 2'b00};
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata_i;
        wstrb_r <= s_axi_wstrb_i;
      end
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        ar_got_r <= 1'b1;
        araddr_r <= {s_axi_araddr_i[11:2], 2'b00};
      end
      if (wr_rdy && rd_rdy) begin
        pri_rd_r <= ~pri_rd_r;
      end
      if (do_wr) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= 2'b00;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
      if (do_rd) begin
        ar_got_r <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= 2'b00;
        s_axi_rdata_o <= {(AXI_DW/32){rd_word}};
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read decode.
  // ----------------------------------------------------------------
  // Unmapped offsets read zero with an OKAY answer.
  always @* begin
    rd_word = 32'h0000_0000;
    if (araddr_r == `SMVO_A_STATUS) begin
      rd_word = {31'h0, busy_r};
    end else if (araddr_r == `SMVO_A_SETOP) begin
      rd_word = {30'h0, setop_r};
    end else if (araddr_r == `SMVO_A_OPSTAT) begin
      rd_word = {opstat_hi_r, `SMVO_BA_RST, 11'h000, opstat_w_r};
    end else if (araddr_r == `SMVO_A_CYC) begin
      rd_word = {28'h0, cyc_r};
    end else if (araddr_r == `SMVO_A_RDATA) begin
      rd_word = {16'h0, rdata_r};
    end else if (araddr_r == `SMVO_A_ECFG) begin
      rd_word = {20'h0, ecfg_r};
    end else if (araddr_r == `SMVO_A_ESTAT) begin
      rd_word = {2'b00, {(22 - CHK_AW){1'b0}}, blk_r, 6'h00, ecc_rsvd, fail_r};
    end else if (araddr_r == `SMVO_A_EVAL) begin
      rd_word = {24'h0, chk_val};
    end else if (araddr_r == `SMVO_A_ICFG) begin
      rd_word = {31'h0, icfg_r};
    end else if (araddr_r == `SMVO_A_IIN) begin
      rd_word = icfg_r ? {{(32 - `SMVO_IIN_W){1'b0}}, in_s2_r} : 32'h0000_0000;
    end else if (araddr_r == `SMVO_A_IOUT) begin
      rd_word = icfg_r ? iout_r : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Register writes, request issue and check engine.
  // ----------------------------------------------------------------
  // A new memory access is only issued while no access is in flight; the
  // payload stays frozen until the acknowledge toggle returns.
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      setop_r <= 2'b00;
      opstat_w_r <= opstat_lo_tie_i;
      opstat_hi_r <= opstat_hi_tie_i;
      cyc_r <= `SMVO_TR_RST;
      ecfg_r <= `SMVO_ECFG_RST;
      icfg_r <= 1'b0;
      iout_r <= `SMVO_IOUT_RST;
      fail_r <= 1'b0;
      blk_r <= {CHK_AW{1'b0}};
      acc_r <= 8'h00;
      exp_r <= 8'h00;
      rdata_r <= 16'h0000;
      req_tgl_r <= 1'b0;
      busy_r <= 1'b0;
      int_req_r <= 1'b0;
      wid_r <= 1'b0;
      kind_r <= `SMVO_K_CMD;
      cs_r <= 2'b00;
      val_r <= 16'h0000;
      tr_r <= 4'h0;
    end else begin
      if (do_wr && wstb[0]) begin
        if (awaddr_r == `SMVO_A_DCMD) begin
          if (wsel[`SMVO_DCMD_HI:`SMVO_DCMD_LO] == `SMVO_DCMD_UPD) begin
            opstat_w_r <= setop_r;
          end
        end else if (awaddr_r == `SMVO_A_SETOP) begin
          setop_r <= wsel[1:0];
        end else if (awaddr_r == `SMVO_A_CYC) begin
          cyc_r <= wsel[3:0];
        end else if (awaddr_r == `SMVO_A_ACC && !busy_r) begin
          req_tgl_r <= ~req_tgl_r;
          busy_r <= 1'b1;
          int_req_r <= 1'b0;
          kind_r <= wsel[`SMVO_ACC_KIND_HI:`SMVO_ACC_KIND_LO];
          cs_r <= wsel[`SMVO_ACC_CS_HI:`SMVO_ACC_CS_LO];
          val_r <= wsel[15:0];
          wid_r <= w16;
          tr_r <= cyc_r;
          if (wsel[`SMVO_ACC_KIND_HI:`SMVO_ACC_KIND_LO] == `SMVO_K_WR) begin
            acc_r <= acc_r ^ fold(wsel[15:0], w16);
          end
        end else if (awaddr_r == `SMVO_A_ECFG) begin
          ecfg_r[7:0] <= wsel[7:0];
        end else if (awaddr_r == `SMVO_A_ESTAT && wsel[0]) begin
          fail_r <= 1'b0;
        end else if (awaddr_r == `SMVO_A_ICFG) begin
          icfg_r <= wsel[0];
        end else if (awaddr_r == `SMVO_A_IOUT && icfg_r) begin
          iout_r <= wsel & `SMVO_IOUT_MASK;
        end
      end
      if (do_wr && wstb[1] && awaddr_r == `SMVO_A_ECFG) begin
        ecfg_r[11:8] <= wsel[11:8];
      end
      // Closing a block stores its check; the memory copy is optional.
      if (close_wr) begin
        blk_r <= blk_r + 1'b1;
        acc_r <= 8'h00;
        if (ecc_mem) begin
          req_tgl_r <= ~req_tgl_r;
          busy_r <= 1'b1;
          int_req_r <= 1'b1;
          kind_r <= `SMVO_K_WR;
          val_r <= {8'h00, acc_r};
          wid_r <= 1'b0;
          tr_r <= cyc_r;
        end
      end
      if (close_rd) begin
        acc_r <= 8'h00;
        exp_r <= acc_r;
        if (ecc_mem) begin
          req_tgl_r <= ~req_tgl_r;
          busy_r <= 1'b1;
          int_req_r <= 1'b1;
          kind_r <= `SMVO_K_RD;
          wid_r <= 1'b0;
          tr_r <= cyc_r;
        end
      end
      // Completion comes last so that a failure beats a same-cycle clear.
      if (ack_ev) begin
        busy_r <= 1'b0;
        if (kind_r == `SMVO_K_RD && int_req_r) begin
          if (mem_rd_r[7:0] != exp_r) begin
            fail_r <= 1'b1;
          end
        end else if (kind_r == `SMVO_K_RD) begin
          rdata_r <= wmask(mem_rd_r, wid_r);
          acc_r <= acc_r ^ fold(mem_rd_r, wid_r);
        end
      end
    end
  end

  smvo_chk_ram #(
    .DW(8),
    .AW(CHK_AW)
  ) u_chk_ram (
    .clock_i(clock_i),
    .wr_en_i(close_wr),
    .wr_addr_i(blk_r),
    .wr_data_i(acc_r),
    .rd_addr_i(ecfg_r[8 +: CHK_AW]),
    .rd_data_o(chk_val)
  );

  // ----------------------------------------------------------------
  // Synchronisers into the bus clock and side-band outputs.
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      in_s1_r <= {`SMVO_IIN_W{1'b0}};
      in_s2_r <= {`SMVO_IIN_W{1'b0}};
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      ack_s3_r <= 1'b0;
    end else begin
      in_s1_r <= {clk_msync0_i, clk_async0_i, ext_bus_backoff0_i, ext_bus_grant0_i,
                  ext_bus_sel_i, low_power_req_i};
      in_s2_r <= in_s1_r;
      ack_s1_r <= ack_m_r;
      ack_s2_r <= ack_s1_r;
      ack_s3_r <= ack_s2_r;
    end
  end

  // In test mode the drive register owns these pins; otherwise the
  // acknowledge simply follows the synchronised request.
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      low_power_active_o <= 1'b0;
      low_power_ack_o <= 1'b0;
      ext_bus_req0_o <= 1'b0;
      mem_int0_o <= 1'b0;
    end else if (icfg_r) begin
      low_power_active_o <= iout_r[0];
      low_power_ack_o <= iout_r[1];
      ext_bus_req0_o <= iout_r[2];
      mem_int0_o <= iout_r[5];
    end else begin
      low_power_active_o <= busy_r | aw_got_r | ar_got_r;
      low_power_ack_o <= in_s2_r[0];
      ext_bus_req0_o <= 1'b0;
      mem_int0_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Memory port 0 sequencer, memory clock domain.
  // ----------------------------------------------------------------
  // Zero-extends the synchronised read data to the 16-bit capture register.
  always @* begin
    dq_wide = 16'h0000;
    dq_wide[MEM_DW-1:0] = dq_m2_r;
  end

  // second clock domain
  // Payload registers are read here only between request and acknowledge.
  // Read data pass two flops, but the first samples the pads one memory clock
  // after the strobe, so the part must hold them for the strobe plus one memory clock.
  always @(posedge memory_port0_clock_i) begin
    if (!mem_rst0_n_i) begin
      req_m1_r <= 1'b0;
      req_m2_r <= 1'b0;
      seen_r <= 1'b0;
      ack_m_r <= 1'b0;
      mux_m1_r <= 1'b0;
      mux_m2_r <= 1'b0;
      dq_m1_r <= {MEM_DW{1'b0}};
      dq_m2_r <= {MEM_DW{1'b0}};
      st_r <= ST_IDLE;
      gap_r <= 4'h0;
      mem_rd_r <= 16'h0000;
      rd_cnt_r <= 2'd0;
    end else begin
      req_m1_r <= req_tgl_r;
      req_m2_r <= req_m1_r;
      mux_m1_r <= mux_mode0_i;
      mux_m2_r <= mux_m1_r;
      dq_m1_r <= mem_dq0_i;
      dq_m2_r <= dq_m1_r;
      case (st_r)
        ST_IDLE: begin
          if (req_m2_r != seen_r) begin
            seen_r <= req_m2_r;
            st_r <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          gap_r <= 4'h1;
          if (kind_r == `SMVO_K_ADDR && mux_m2_r) begin
            st_r <= ST_HOLD;
          end else if (kind_r == `SMVO_K_RD) begin
            // Data driven after the strobe need two more edges to reach dq_m2_r.
            rd_cnt_r <= 2'd3;
            st_r <= ST_GAP;
          end else if (mux_m2_r && tr_r != 4'h0) begin
            st_r <= ST_GAP;
          end else begin
            st_r <= ST_IDLE;
            ack_m_r <= ~ack_m_r;
          end
        end
        ST_HOLD: begin
          if (tr_r != 4'h0) begin
            st_r <= ST_GAP;
          end else begin
            st_r <= ST_IDLE;
            ack_m_r <= ~ack_m_r;
          end
        end
        default: begin
          if (rd_cnt_r != 2'd0) begin
            // Pads are idle during the read wait, so it only lengthens the gap.
            rd_cnt_r <= rd_cnt_r - 2'd1;
            if (rd_cnt_r == 2'd1) begin
              mem_rd_r <= dq_wide;
            end
          end else if (!mux_m2_r || gap_r >= tr_r) begin
            st_r <= ST_IDLE;
            ack_m_r <= ~ack_m_r;
          end else begin
            gap_r <= gap_r + 4'h1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pad launch on the inverted memory clock.
  // ----------------------------------------------------------------
  wire strobe = (st_r == ST_STROBE);
  wire hold = (st_r == ST_HOLD);
  wire [3:0] cs_oh = cs_dec(cs_r);
  wire [15:0] dq_out = wmask(val_r, wid_r);

  always @(posedge memory_port0_clock_n_i) begin
    if (!mem_rst0_n_i) begin
      mem_cs0_n_o <= {NUM_CS{1'b1}};
      mem_cle0_o <= 1'b0;
      mem_adv0_n_o <= 1'b1;
      mem_we0_n_o <= 1'b1;
      mem_re0_n_o <= 1'b1;
      mem_dq0_o <= {MEM_DW{1'b0}};
      mem_dq0_oe_o <= 1'b0;
    end else begin
      mem_cs0_n_o <= ~(cs_oh[NUM_CS-1:0] & {NUM_CS{strobe | hold}});
      mem_cle0_o <= strobe && kind_r == `SMVO_K_CMD;
      mem_adv0_n_o <= !(strobe && kind_r == `SMVO_K_ADDR);
      mem_we0_n_o <= !(strobe && kind_r != `SMVO_K_RD);
      mem_re0_n_o <= !(strobe && kind_r == `SMVO_K_RD);
      mem_dq0_o <= dq_out[MEM_DW-1:0];
      mem_dq0_oe_o <= (strobe && kind_r != `SMVO_K_RD) || hold;
    end
  end

endmodule

// >>> smvo_properties.sv
// Bus-side checker for the static memory controller register block.
// Assumes it is bound to smvo_ctrl and sees only its ports.
`timescale 1ns/10ps

module smvo_properties #(
  parameter AXI_DW = 32
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arready_o,
  input wire logic [AXI_DW-1:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  // All checks sit in the bus clock domain.
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  chk_bresp_low: assert property (s_axi_bvalid_o |-> s_axi_bresp_o == 2'b00)
    else $error("write response not okay");
  chk_bvalid_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  chk_rvalid_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped early");
  chk_read_answer: assert property (s_axi_arready_o |=> ##[0:2] s_axi_rvalid_o)
    else $error("read answer late");
  chk_one_write: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while response pending");
  chk_one_read: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while data pending");
  chk_aw_pulse: assert property (s_axi_awready_o |=> !s_axi_awready_o)
    else $error("address ready longer than one cycle");
  chk_ar_pulse: assert property (s_axi_arready_o |=> !s_axi_arready_o)
    else $error("read ready longer than one cycle");
  chk_rresp_okay: assert property (s_axi_rvalid_o |-> s_axi_rresp_o == 2'b00)
    else $error("read response not okay");
endmodule

// >>> smvo_nand_model.sv
// Behavioural flash part on memory port 0, one cell deep.
// Assumes pads launch on the falling memory clock edge.
`timescale 1ns/10ps

module smvo_nand_model (
  input wire logic mclk_i,
  input wire logic cs_n_i,
  input wire logic we_n_i,
  input wire logic re_n_i,
  input wire logic [15:0] d_i,
  output logic [15:0] q_o
);
  logic [15:0] cell_r = 16'h0;
  logic [1:0] hold_r = 2'h0;

  initial q_o = 16'h0;
  // sample half a cycle after launch
  // Data held three cycles for the two-flop capture; otherwise the bus toggles so stale data never matches.
  always @(posedge mclk_i) begin
    if (!cs_n_i && !we_n_i) cell_r <= d_i;
    hold_r <= (!cs_n_i && !re_n_i) ? 2'h3 : hold_r - (hold_r != 2'h0);
    q_o <= ((!cs_n_i && !re_n_i) || hold_r != 2'h0) ? cell_r : ~q_o;
  end
endmodule

// >>> smvo_tb.sv
// Self-checking bench: AXI4-Lite master, expectation queues, flash model.
// Assumes the checker and model files are compiled first.
`timescale 1ns/10ps
`include "smvo_map.vh"

module tb;
  logic clock_i = 0, rst_n_i = 0, mclk = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, mux = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, r;
  logic [15:0] tie_hi, q;
  logic [1:0] tie_lo;
  logic [5:0] pins;
  logic [31:0] qr[$];
  logic [1:0] qb[$];
  logic cs_n, we_n, re_n;
  logic [15:0] dq;
  logic [31:0] rdata;
  logic [1:0] bresp;
  logic awr, wr_r, bv, arr, rv;
  int n_errors = 0, checks_done = 0, c, g;

  always #10 clock_i = ~clock_i;
  always #15 mclk = ~mclk;

  smvo_ctrl dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr_r), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(), .s_axi_rvalid_o(rv), .s_axi_rready_i(rready), .memory_port0_clock_i(mclk),
    .memory_port0_clock_n_i(~mclk), .mem_rst0_n_i(rst_n_i), .mux_mode0_i(mux), .opstat_hi_tie_i(tie_hi),
    .opstat_lo_tie_i(tie_lo), .low_power_req_i(pins[0]), .ext_bus_sel_i(pins[1]), .ext_bus_grant0_i(pins[2]),
    .ext_bus_backoff0_i(pins[3]), .clk_async0_i(pins[4]), .clk_msync0_i(pins[5]), .low_power_active_o(),
    .low_power_ack_o(), .ext_bus_req0_o(), .mem_int0_o(), .mem_cs0_n_o(cs_n), .mem_cle0_o(),
    .mem_adv0_n_o(), .mem_we0_n_o(we_n), .mem_re0_n_o(re_n), .mem_dq0_o(dq), .mem_dq0_oe_o(), .mem_dq0_i(q));
  smvo_nand_model mem_u (.mclk_i(mclk), .cs_n_i(cs_n), .we_n_i(we_n), .re_n_i(re_n), .d_i(dq), .q_o(q));

  task automatic results();
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Requests stay up until their own ready edge; waits are bounded.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1; qb.push_back(2'b00);
    for (n = 0; n < 60; n++) begin
      @(posedge clock_i);
      if (awr) awv <= 0;
      if (wr_r) wv <= 0;
      if (bv) break;
    end
    bready <= 0;
    if (n == 60) begin n_errors++; results(); end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    int n;
    @(posedge clock_i);
    araddr <= a; arv <= 1; rready <= 1; qr.push_back(e);
    for (n = 0; n < 60; n++) begin
      @(posedge clock_i);
      if (arr) arv <= 0;
      if (rv) break;
    end
    rready <= 0;
    if (n == 60) begin n_errors++; results(); end
  endtask

  // Results are matched against the oldest note as they are taken.
  always @(posedge clock_i) begin
    if (rv && rready) cmp("rdata", qr.pop_front(), rdata);
    if (bv && bready) cmp("bresp", {30'h0, qb.pop_front()}, {30'h0, bresp});
  end

  initial begin
    void'($urandom(32'he62c));
    tie_hi = $urandom; tie_lo = {1'($urandom), 1'b0}; pins = $urandom;
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1;
    rd(`SMVO_A_OPSTAT, {tie_hi, 14'h0, tie_lo});
    rd(`SMVO_A_IIN, 0);
    rd(`SMVO_A_IOUT, 0);
    wr(12'h800, 32'hffffffff);
    rd(12'h800, 0);
    wr(`SMVO_A_ICFG, 1);
    rd(`SMVO_A_IIN, {26'h0, pins});
    r = $urandom;
    wr(`SMVO_A_IOUT, r);
    rd(`SMVO_A_IOUT, r & `SMVO_IOUT_MASK);
    wr(`SMVO_A_IOUT, 32'h2); // acknowledge high first
    wr(`SMVO_A_ICFG, 0);
    wr(`SMVO_A_SETOP, 32'hfffffffd);
    for (c = 0; c < 4; c++) begin
      g = c ^ (c >> 1);
      wr(`SMVO_A_DCMD, g << 21);
      repeat (20) @(posedge clock_i);
      rd(`SMVO_A_OPSTAT, {tie_hi, 14'h0, (c == 3) ? `SMVO_W16 : tie_lo});
    end
    for (c = 0; c < 2; c++) begin
      mux <= c[0];
      r = $urandom;
      wr(`SMVO_A_ACC, {14'h0, `SMVO_K_WR, r[15:0]});
      repeat (20) @(posedge clock_i);
      rd(`SMVO_A_STATUS, 0);
      wr(`SMVO_A_ACC, {14'h0, `SMVO_K_RD, 16'h0});
      repeat (20) @(posedge clock_i);
      rd(`SMVO_A_RDATA, {16'h0, r[15:0]});
    end
    wr(`SMVO_A_ECMD, 1);
    repeat (20) @(posedge clock_i);
    wr(`SMVO_A_ECFG, 0);
    rd(`SMVO_A_ESTAT, 32'h102);
    results();
  end
endmodule

bind smvo_ctrl smvo_properties #(.AXI_DW(AXI_DW)) chk_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i));
